// ===== core/dass_cfg.svh
// Offsets, field positions, reset values and codes of the source selector
`ifndef DASS_CFG_SVH
`define DASS_CFG_SVH
// Register byte addresses (one aligned word each)
`define DASS_CTRL_A_OFS    8'h00
`define DASS_CTRL_B_OFS    8'h04
`define DASS_ENABLE_OFS    8'h08
`define DASS_STATUS_OFS    8'h0c
`define DASS_ADDR_W        8
// Control register layout
`define DASS_CTRL_W        8
`define DASS_CTRL_RESET    8'h00
`define DASS_SEL_MSB       3
`define DASS_SEL_LSB       0
// Activation codes
`define DASS_CODE_ADC      4'h1
`define DASS_CODE_PIN_EDGE 4'h2
`define DASS_CODE_PIN_LVL  4'h3
`define DASS_CODE_SER_LO   4'h4
`define DASS_CODE_SER_HI   4'h7
`define DASS_CODE_TMR_LO   4'h8
`define DASS_CODE_TMR_HI   4'hd
// Bus responses
`define DASS_RESP_OKAY     2'b00
`define DASS_RESP_SLVERR   2'b10
`endif

// ===== core/dass_pkg.sv
// Types shared by the source selector files
package dass_pkg;
  // Which channel a decoder serves
  typedef enum logic {DASS_CH_A, DASS_CH_B} dass_chan_t;
  // Bus slave phases
  typedef enum logic [1:0] {DASS_IDLE, DASS_WAIT_B, DASS_WAIT_R}
    dass_bus_t;
endpackage

// ===== core/dass_decode.sv
// Decoder: activation code plus peripheral requests to one trigger
`timescale 1ns/1ps
`include "dass_cfg.svh"
module dass_decode #(
  parameter dass_pkg::dass_chan_t CHAN = dass_pkg::DASS_CH_A
) (
  // Selection
  input  wire logic [3:0]  sel,
  // Peripheral requests
  input  wire logic        adc_req,
  input  wire logic [3:0]  ser_req,
  input  wire logic [5:0]  tmr_req,
  // Qualified pin events (channel B only)
  input  wire logic        pin_edge,
  input  wire logic        pin_low,
  // Result
  output logic             trig,
  output logic             bad_code
);
  // Map code to its event; prohibited codes give no trigger
  always_comb
  begin
    trig     = 1'b0;
    bad_code = 1'b0;
    if (sel == `DASS_CODE_ADC)
      trig = adc_req;                                   // [R02]
    else if (sel >= `DASS_CODE_SER_LO && sel <= `DASS_CODE_SER_HI)
      trig = ser_req[sel[1:0]];                         // [R03]
    else if (sel >= `DASS_CODE_TMR_LO && sel <= `DASS_CODE_TMR_HI)
      trig = tmr_req[3'(sel - `DASS_CODE_TMR_LO)];      // [R04]
    else if (CHAN == dass_pkg::DASS_CH_B && sel == `DASS_CODE_PIN_EDGE)
      trig = pin_edge;                                  // [R06]
    else if (CHAN == dass_pkg::DASS_CH_B && sel == `DASS_CODE_PIN_LVL)
      trig = pin_low;                                   // [R07]
    else
      bad_code = 1'b1;                                  // [R09]
  end
endmodule

// ===== core/dass_top.sv
// Activation source selection for channels A and B with AXI4-Lite regs
// Notes on behaviour
// [R01] Four-bit read/write source field, bits 3..0, reset to zero.
// [R02] Code 0001 starts on converter conversion-end request.
// [R03] Codes 0100..0111: serial 0 tx, 0 rx, 1 tx, 1 rx complete.
// [R04] Codes 1000..1101: timer channels 0..5 compare/capture A.
// [R05] Software never writes prohibited codes (A: 0,2,3,e,f; B: 0,e,f).
// [R06] Channel B code 0010: pin falling edge; first after enable on low.
// [R07] Channel B code 0011: transfer while request pin held low.
// [R08] Shared source: higher priority channel (A) served first; B's trigger is dropped while go_a is high and is not served later.
// [R09] Prohibited code present: no activation at all.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "dass_cfg.svh"
module dass_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Peripheral requests (same clock)
  input  wire logic        adc_req,
  input  wire logic [3:0]  serial_comm_unit_req,
  input  wire logic [5:0]  pulse_timer_unit_req,
  // External request pin, active low, asynchronous
  input  wire logic        external_transfer_request_pin_n,
  // Activation to the transfer engine
  output logic             start_a,
  output logic             start_b
);
  logic [7:0]  ctrl_a;
  logic [7:0]  ctrl_b;
  logic [1:0]  enable;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        req_s1;
  logic        req_s2;
  logic        req_prev;
  logic        first_b;
  logic        trig_a;
  logic        trig_b;
  logic        bad_a;
  logic        bad_b;
  logic        pin_low;
  logic        pin_edge;
  logic        do_write;
  logic        go_a;
  logic        go_b;

  // Register read mux, shared by the read channel
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    case (a)
      `DASS_CTRL_A_OFS: rd_mux = {24'h0, ctrl_a};
      `DASS_CTRL_B_OFS: rd_mux = {24'h0, ctrl_b};
      `DASS_ENABLE_OFS: rd_mux = {30'h0, enable};
      `DASS_STATUS_OFS: rd_mux = {28'h0, bad_b, bad_a, start_b, start_a};
      default:          rd_mux = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `DASS_CTRL_A_OFS) || (a == `DASS_CTRL_B_OFS) ||
             (a == `DASS_ENABLE_OFS) || (a == `DASS_STATUS_OFS);
  endfunction

  // Address and data are caught independently, in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DASS_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr) ? `DASS_RESP_OKAY : `DASS_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control registers; only byte lane 0 carries bits
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_a <= `DASS_CTRL_RESET;                       // [R01]
      ctrl_b <= `DASS_CTRL_RESET;                       // [R01]
      enable <= 2'b00;
    end
    else if (do_write && w_strb[0])
    begin
      case (aw_addr)
        `DASS_CTRL_A_OFS: ctrl_a <= w_data[7:0];        // [R01]
        `DASS_CTRL_B_OFS: ctrl_b <= w_data[7:0];        // [R01]
        `DASS_ENABLE_OFS: enable <= w_data[1:0];
        default:          ;
      endcase
    end
  end

  // Read channel: data registered, answer one cycle after arvalid
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `DASS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux(s_axi_araddr);
      s_axi_rresp  <= mapped(s_axi_araddr) ? `DASS_RESP_OKAY
                                           : `DASS_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Pin synchroniser; the second stage and its delayed copy req_prev are looked at
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req_s1   <= 1'b1;
      req_s2   <= 1'b1;
      req_prev <= 1'b1;
    end
    else
    begin
      req_s1   <= external_transfer_request_pin_n;
      req_s2   <= req_s1;
      req_prev <= req_s2;
    end
  end

  // First transfer after enable is level triggered, later ones edge.
  // Cleared on the qualified trigger, not the registered start: waiting
  // one more cycle would let a still-low pin trigger a second time.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      first_b <= 1'b1;
    else if (!enable[1])
      first_b <= 1'b1;                                  // [R06]
    else if (go_b)
      first_b <= 1'b0;                                  // [R06]
  end

  assign pin_low  = !req_s2;                            // [R07]
  assign pin_edge = first_b ? !req_s2 : (req_prev && !req_s2); // [R06]

  dass_decode #(.CHAN(dass_pkg::DASS_CH_A)) u_dec_a (
    .sel      (ctrl_a[`DASS_SEL_MSB:`DASS_SEL_LSB]),
    .adc_req  (adc_req),
    .ser_req  (serial_comm_unit_req),
    .tmr_req  (pulse_timer_unit_req),
    .pin_edge (1'b0),
    .pin_low  (1'b0),
    .trig     (trig_a),
    .bad_code (bad_a)
  );

  dass_decode #(.CHAN(dass_pkg::DASS_CH_B)) u_dec_b (
    .sel      (ctrl_b[`DASS_SEL_MSB:`DASS_SEL_LSB]),
    .adc_req  (adc_req),
    .ser_req  (serial_comm_unit_req),
    .tmr_req  (pulse_timer_unit_req),
    .pin_edge (pin_edge),
    .pin_low  (pin_low),
    .trig     (trig_b),
    .bad_code (bad_b)
  );

  // Qualified triggers; a shared source goes to A, B's trigger is dropped while A goes
  assign go_a = enable[0] && trig_a && !bad_a;          // [R09]
  assign go_b = enable[1] && trig_b && !bad_b && !go_a; // [R08] [R09]

  // Arbitration: a shared source starts A in each cycle it is asserted;
  // B never starts on it while go_a is high; B's trigger is dropped, not held, while A starts.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      start_a <= 1'b0;
      start_b <= 1'b0;
    end
    else
    begin
      start_a <= go_a;                                  // [R09]
      start_b <= go_b;                                  // [R08]
    end
  end

  // Assertions
  a_prio_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (enable[0] && trig_a && !bad_a) |=> !start_b) // [R08]
    else $error("channel B started beside channel A");
  a_bad_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (bad_a && $stable(ctrl_a)) |=> !start_a) // [R09]
    else $error("prohibited code on A started a transfer");
  a_adc_start: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_a[3:0] == 4'h1 && enable[0] && adc_req) |=> start_a) // [R02]
    else $error("converter request missed on A");
  a_lvl_start: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_b[3:0] == 4'h3 && enable[1] && !go_a && !req_s2)
      |=> start_b) // [R07]
    else $error("low pin did not start B");
  a_edge_once: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_b[3:0] == `DASS_CODE_PIN_EDGE && start_b && !req_prev &&
     !req_s2) |=> !start_b) // [R06]
    else $error("held low pin started B twice in edge mode");
  a_reset_zero: assert property (@(posedge clk)
    $fell(sys_rst) |-> ctrl_a == 8'h00 && ctrl_b == 8'h00) // [R01]
    else $error("control not zero after reset");
endmodule

// ===== verification/dass_src_model.sv
// Peripheral request sources and request pin facing the selector
`timescale 1ns/1ps
module dass_src_model (
  // Clock
  input  wire logic clk,
  // Requests toward the selector
  output logic       adc_req,
  output logic [3:0] ser_req,
  output logic [5:0] tmr_req,
  output logic       pin_n
);
  // Quiet sources; the pin idles high on its pull-up
  initial
  begin
    {tmr_req, ser_req, adc_req} = 11'h000;
    pin_n = 1'b1;
  end

  // Raise a source mask for n cycles; bit 0 converter, 1-4 serial, 5-10 timer
  task automatic pulse(input logic [10:0] m, input int n);
    begin
      @(posedge clk);
      {tmr_req, ser_req, adc_req} <= m;
      repeat (n) @(posedge clk);
      {tmr_req, ser_req, adc_req} <= 11'h000;
    end
  endtask

  // Drive the pin low to ask for service, high to withdraw
  task automatic pin(input logic lvl, input int n);
    begin
      @(posedge clk);
      pin_n <= lvl;
      repeat (n) @(posedge clk);
    end
  endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the activation source selector
`timescale 1ns/1ps
`include "dass_cfg.svh"
module tb;
  logic        clk, sys_rst, adc_req, pin_n, start_a, start_b;
  logic [3:0]  ser_req, s_axi_wstrb;
  logic [5:0]  tmr_req;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          miscompares, compares, cnt_a, cnt_b;
  logic [1:0]  last_bresp;
  localparam logic [3:0] bad_codes [5] = '{4'h0, 4'h2, 4'h3, 4'he, 4'hf};

  dass_top dut_u (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_req,
    .serial_comm_unit_req(ser_req), .pulse_timer_unit_req(tmr_req),
    .external_transfer_request_pin_n(pin_n), .start_a, .start_b);
  dass_src_model src_u (.clk, .adc_req, .ser_req, .tmr_req, .pin_n);

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Start tallies; a window difference tells how many starts occurred
  always @(posedge clk)
  begin
    if (start_a !== 1'b0)
      cnt_a <= cnt_a + 1;
    if (start_b !== 1'b0)
      cnt_b <= cnt_b + 1;
  end

  task automatic conclude();
    begin
      if (miscompares == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // A hung handshake counts as a mismatch and ends the run
  task automatic stall();
    begin
      miscompares++;
      conclude();
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("CHECK FAILED %0t saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Write one word; address and data offered together, released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic aw_go;
    logic w_go;
    logic b_go;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
        // Settled levels before the edge that completes each handshake
        @(negedge clk);
        aw_go = s_axi_awvalid && s_axi_awready;
        w_go = s_axi_wvalid && s_axi_wready;
        b_go = s_axi_bvalid;
        if (b_go)
          last_bresp = s_axi_bresp;
        @(posedge clk);
        if (aw_go)
          s_axi_awvalid <= 1'b0;
        if (w_go)
          s_axi_wvalid <= 1'b0;
        if (b_go)
          break;
      end
      s_axi_bready <= 1'b0;
      if (n == 16)
        stall();
    end
  endtask

  // Read one word and its response code
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int   n;
    logic ar_go;
    logic r_go;
    begin
      d = 32'h0;
      r = 2'b00;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
        // Data stands until the edge at which rready is seen high
        @(negedge clk);
        ar_go = s_axi_arvalid && s_axi_arready;
        r_go = s_axi_rvalid;
        if (r_go)
        begin
          d = s_axi_rdata;
          r = s_axi_rresp;
        end
        @(posedge clk);
        if (ar_go)
          s_axi_arvalid <= 1'b0;
        if (r_go)
          break;
      end
      s_axi_rready <= 1'b0;
      if (n == 16)
        stall();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    begin
      axi_rd(a, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, `DASS_RESP_OKAY});
    end
  endtask

  // Fire a source mask, then compare start counts of both channels
  task automatic fire(input logic [10:0] m, input int ea, input int eb);
    int ba, bb;
    begin
      ba = cnt_a;
      bb = cnt_b;
      src_u.pulse(m, 1);
      repeat (6) @(posedge clk);
      check(cnt_a - ba, ea);
      check(cnt_b - bb, eb);
    end
  endtask

  // Reset values, read-back, and an unmapped read
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    begin
      rd_chk(`DASS_CTRL_A_OFS, 32'h0);
      rd_chk(`DASS_CTRL_B_OFS, 32'h0);
      rd_chk(`DASS_ENABLE_OFS, 32'h0);
      // Code 0000 is prohibited on both channels: both bad flags show
      rd_chk(`DASS_STATUS_OFS, 32'hc);
      axi_wr(`DASS_CTRL_A_OFS, 32'h0000005a);
      check({30'h0, last_bresp}, {30'h0, `DASS_RESP_OKAY});
      rd_chk(`DASS_CTRL_A_OFS, 32'h0000005a);
      // Lane 0 strobe low: the write must leave the register alone
      s_axi_wstrb <= 4'he;
      axi_wr(`DASS_CTRL_A_OFS, 32'h000000ff);
      s_axi_wstrb <= 4'hf;
      rd_chk(`DASS_CTRL_A_OFS, 32'h0000005a);
      axi_wr(8'h10, 32'h1);
      check({30'h0, last_bresp}, {30'h0, `DASS_RESP_SLVERR});
      axi_rd(8'h10, d, r);
      check(d, 32'h0);
      check({30'h0, r}, {30'h0, `DASS_RESP_SLVERR});
    end
  endtask

  // Every code legal on both channels; a shared pulse goes to A only
  task automatic t_codes();
    int i;
    logic [3:0] c;
    begin
      axi_wr(`DASS_ENABLE_OFS, 32'h3);
      for (i = 0; i < 11; i++)
      begin
        c = (i == 0) ? 4'h1 : 4'(i + 3);
        axi_wr(`DASS_CTRL_A_OFS, {28'h0, c});
        axi_wr(`DASS_CTRL_B_OFS, {28'h0, c});
        fire(11'h001 << i, 1, 0);
        fire(~(11'h001 << i), 0, 0);
      end
      axi_wr(`DASS_CTRL_A_OFS, 32'h0);
      axi_wr(`DASS_CTRL_B_OFS, 32'h1);
      fire(11'h001, 0, 1);
    end
  endtask

  // Prohibited codes on both channels never start anything
  task automatic t_bad();
    int i;
    begin
      for (i = 0; i < 5; i++)
      begin
        axi_wr(`DASS_CTRL_A_OFS, {28'h0, bad_codes[i]});
        axi_wr(`DASS_CTRL_B_OFS,
               {28'h0, bad_codes[(i % 3 == 0) ? 0 : i % 3 + 2]});
        fire(11'h7ff, 0, 0);
      end
    end
  endtask

  // Pin level mode, then edge mode with its first start on a low level
  task automatic t_pin();
    int bb;
    begin
      axi_wr(`DASS_CTRL_B_OFS, {28'h0, `DASS_CODE_PIN_LVL});
      bb = cnt_b;
      src_u.pin(1'b0, 4);
      src_u.pin(1'b1, 6);
      // Pin stays low for five clock periods: one start per period
      check(cnt_b - bb, 5);
      axi_wr(`DASS_ENABLE_OFS, 32'h1);
      axi_wr(`DASS_CTRL_B_OFS, {28'h0, `DASS_CODE_PIN_EDGE});
      src_u.pin(1'b0, 2);
      bb = cnt_b;
      axi_wr(`DASS_ENABLE_OFS, 32'h3);
      src_u.pin(1'b0, 8);
      check(cnt_b - bb, 1);
      src_u.pin(1'b1, 4);
      src_u.pin(1'b0, 8);
      check(cnt_b - bb, 2);
      src_u.pin(1'b1, 4);
    end
  endtask

  // Main sequence
  initial
  begin
    {miscompares, compares, cnt_a, cnt_b} = '0;
    last_bresp = 2'b11;
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_codes();
    t_bad();
    t_pin();
    conclude();
  end
endmodule
